/* verilog/thermal_charge_profile_regs.sv */
// Thermal charging profile register bank with zone-based charge adjustment.
// Assumes an upstream serial decoder gives same-clock write/read strobes and
// an ADC gives a same-clock thermistor code.
// Operation
// - Warm voltage field bits 6:4, reset 011
// - Current scale field bits 2:0, reset 100
// - Adjust register 0x61 resets 0x34, reserved RW
// - Cold limit at 0x62, reset 0x7C
// - Cool limit at 0x63, reset 0x6D
// - Warm limit at 0x64, reset 0x38
// - Hot limit at 0x65, reset 0x27
// - Read-only part identifier at 0x6F
`timescale 1ns/1ns
`default_nettype none
`include "thermal_profile_defs.svh"
module thermal_charge_profile_regs #(
	// Arbitrary neutral identifier value
	parameter logic [7:0] PART_ID_VALUE = 8'h5C
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] thermistor_sense,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic [8:0] vbat_reduction_mv,
	output logic [3:0] current_scale_eighths,
	output logic charge_suspend,
	output var thermal_profile_pkg::temp_zone_t zone_out
);
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;
	logic [7:0] adjust_reg;
	logic [7:0] cold_reg;
	logic [7:0] cool_reg;
	logic [7:0] warm_reg;
	logic [7:0] hot_reg;
	logic [7:0] rd_data_next;
	thermal_profile_pkg::temp_zone_t zone;

	// Reset released through two flops so release is clean to sys_clk
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
		addr_hit = (a == ofs);
	endfunction

	// Whole byte stored, reserved bits 7 and 3 included
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			adjust_reg <= `RST_THERMAL_ADJUST;
		end else if (wr_en && addr_hit(reg_addr, `OFS_THERMAL_ADJUST)) begin
			adjust_reg <= wr_data;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cold_reg <= `RST_COLD_LIMIT;
			cool_reg <= `RST_COOL_LIMIT;
			warm_reg <= `RST_WARM_LIMIT;
			hot_reg <= `RST_HOT_LIMIT;
		end else if (wr_en) begin
			if (addr_hit(reg_addr, `OFS_COLD_LIMIT)) begin
				cold_reg <= wr_data;
			end
			if (addr_hit(reg_addr, `OFS_COOL_LIMIT)) begin
				cool_reg <= wr_data;
			end
			if (addr_hit(reg_addr, `OFS_WARM_LIMIT)) begin
				warm_reg <= wr_data;
			end
			if (addr_hit(reg_addr, `OFS_HOT_LIMIT)) begin
				hot_reg <= wr_data;
			end
		end
	end

	// Identifier has no storage, so writes to it cannot land
	always_comb begin
		case (reg_addr)
			`OFS_THERMAL_ADJUST: rd_data_next = adjust_reg;
			`OFS_COLD_LIMIT: rd_data_next = cold_reg;
			`OFS_COOL_LIMIT: rd_data_next = cool_reg;
			`OFS_WARM_LIMIT: rd_data_next = warm_reg;
			`OFS_HOT_LIMIT: rd_data_next = hot_reg;
			`OFS_PART_ID: rd_data_next = PART_ID_VALUE;
			default: rd_data_next = `READ_IDLE;
		endcase
	end

	// Read data is registered so the serial shifter always sees a settled byte
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= `READ_IDLE;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_en;
			if (rd_en) begin
				rd_data <= rd_data_next;
			end
		end
	end

	// Zone decision kept apart so the limit compares can be checked alone
	thermal_zone_classifier u_classifier (
		.sense_code(thermistor_sense),
		.cold_limit_code(cold_reg),
		.cool_limit_code(cool_reg),
		.warm_limit_code(warm_reg),
		.hot_limit_code(hot_reg),
		.zone(zone)
	);

	// Current scaling applies in cool and warm; charging stops at cold and hot
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			zone_out <= thermal_profile_pkg::zone_normal;
			vbat_reduction_mv <= `VRED_NONE;
			current_scale_eighths <= `SCALE_FULL;
			charge_suspend <= 1'b0;
		end else begin
			zone_out <= zone;
			charge_suspend <= (zone == thermal_profile_pkg::zone_cold) ||
				(zone == thermal_profile_pkg::zone_hot);
			if (zone == thermal_profile_pkg::zone_warm) begin
				vbat_reduction_mv <= 9'(adjust_reg[`WVR_MSB:`WVR_LSB] * `VRED_STEP_MV);
			end else begin
				vbat_reduction_mv <= `VRED_NONE;
			end
			if (zone == thermal_profile_pkg::zone_warm ||
				zone == thermal_profile_pkg::zone_cool) begin
				current_scale_eighths <= `SCALE_FULL - {1'b0, adjust_reg[`TCS_MSB:`TCS_LSB]};
			end else begin
				current_scale_eighths <= `SCALE_FULL;
			end
		end
	end

	a_write_adjust: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_en && reg_addr == `OFS_THERMAL_ADJUST |=> adjust_reg == $past(wr_data))
		else $error("adjust register write lost");
	// Back-to-back write then read of one limit, taken as two steps
	sequence s_cold_write;
		wr_en && reg_addr == `OFS_COLD_LIMIT;
	endsequence
	sequence s_cold_read;
		rd_en && reg_addr == `OFS_COLD_LIMIT;
	endsequence
	a_write_cold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_cold_write ##1 s_cold_read |=> rd_data == $past(wr_data, 2))
		else $error("cold limit readback wrong");
	a_write_cool: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_en && reg_addr == `OFS_COOL_LIMIT |=> cool_reg == $past(wr_data))
		else $error("cool limit write lost");
	a_write_warm: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_en && reg_addr == `OFS_WARM_LIMIT |=> warm_reg == $past(wr_data))
		else $error("warm limit write lost");
	a_write_hot: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_en && reg_addr == `OFS_HOT_LIMIT |=> hot_reg == $past(wr_data))
		else $error("hot limit write lost");
	a_part_id_fixed: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rd_en && reg_addr == `OFS_PART_ID |=> rd_valid && rd_data == PART_ID_VALUE)
		else $error("identifier read wrong");
	a_warm_vred: assert property (@(posedge sys_clk) disable iff (!rst_n)
		zone == thermal_profile_pkg::zone_warm
		|=> vbat_reduction_mv == 9'($past(adjust_reg[`WVR_MSB:`WVR_LSB]) * `VRED_STEP_MV))
		else $error("warm voltage reduction wrong");
	a_cool_scale: assert property (@(posedge sys_clk) disable iff (!rst_n)
		zone == thermal_profile_pkg::zone_cool
		|=> current_scale_eighths == 4'h8 - {1'b0, $past(adjust_reg[`TCS_MSB:`TCS_LSB])})
		else $error("current scale wrong");
	a_hot_suspend: assert property (@(posedge sys_clk) disable iff (!rst_n)
		thermistor_sense <= hot_reg |=> charge_suspend && vbat_reduction_mv == 9'h000)
		else $error("hot zone not suspended");
	a_hot_full_scale: assert property (@(posedge sys_clk) disable iff (!rst_n)
		zone == thermal_profile_pkg::zone_hot
		|=> current_scale_eighths == `SCALE_FULL && zone_out == thermal_profile_pkg::zone_hot)
		else $error("hot zone scale wrong");
	a_cold_suspend: assert property (@(posedge sys_clk) disable iff (!rst_n)
		zone == thermal_profile_pkg::zone_cold
		|=> charge_suspend && current_scale_eighths == `SCALE_FULL)
		else $error("cold zone not suspended");
	a_cool_no_vred: assert property (@(posedge sys_clk) disable iff (!rst_n)
		zone == thermal_profile_pkg::zone_cool
		|=> vbat_reduction_mv == `VRED_NONE && !charge_suspend)
		else $error("cool zone voltage reduced");
	a_warm_scale: assert property (@(posedge sys_clk) disable iff (!rst_n)
		zone == thermal_profile_pkg::zone_warm
		|=> current_scale_eighths == `SCALE_FULL - {1'b0, $past(adjust_reg[`TCS_MSB:`TCS_LSB])})
		else $error("warm current scale wrong");
	a_normal_full: assert property (@(posedge sys_clk) disable iff (!rst_n)
		zone == thermal_profile_pkg::zone_normal
		|=> !charge_suspend && vbat_reduction_mv == `VRED_NONE &&
		current_scale_eighths == `SCALE_FULL)
		else $error("normal zone not at full charge");
	a_id_write_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_en && reg_addr == `OFS_PART_ID |=> $stable(adjust_reg) && $stable(cold_reg) &&
		$stable(cool_reg) && $stable(warm_reg) && $stable(hot_reg))
		else $error("identifier write changed a register");
	// Read port timing: one-cycle valid pulse, data held between reads
	a_read_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> rd_valid == $past(rd_en))
		else $error("read valid pulse wrong");
	a_read_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!rd_en |=> $stable(rd_data))
		else $error("read data changed without a read");
	a_zone_track: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> zone_out == $past(zone))
		else $error("zone output lags wrong");
endmodule
`default_nettype wire

/* verilog/thermal_profile_defs.svh */
// Register offsets, reset values, field positions and output scale constants for the thermal profile bank.
// Assumes an 8-bit register address and 8-bit data from the serial register port.
`ifndef THERMAL_PROFILE_DEFS_SVH
`define THERMAL_PROFILE_DEFS_SVH
`define OFS_THERMAL_ADJUST 8'h61
`define OFS_COLD_LIMIT 8'h62
`define OFS_COOL_LIMIT 8'h63
`define OFS_WARM_LIMIT 8'h64
`define OFS_HOT_LIMIT 8'h65
`define OFS_PART_ID 8'h6F
`define RST_THERMAL_ADJUST 8'h34
`define RST_COLD_LIMIT 8'h7C
`define RST_COOL_LIMIT 8'h6D
`define RST_WARM_LIMIT 8'h38
`define RST_HOT_LIMIT 8'h27
`define WVR_MSB 6
`define WVR_LSB 4
`define TCS_MSB 2
`define TCS_LSB 0
`define VRED_STEP_MV 8'h32
`define READ_IDLE 8'h00
`define SCALE_FULL 4'h8
`define VRED_NONE 9'h000
`endif

/* verilog/thermal_profile_pkg.sv */
// Types shared by the thermal profile bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package thermal_profile_pkg;
	typedef enum logic [2:0] {
		zone_normal,
		zone_cool,
		zone_warm,
		zone_cold,
		zone_hot
	} temp_zone_t;
endpackage
`default_nettype wire

/* verilog/thermal_zone_classifier.sv */
// Classifies a thermistor code against four limits into a temperature zone.
// Assumes same-clock inputs; thermistor voltage falls as temperature rises.
`timescale 1ns/1ns
`default_nettype none
module thermal_zone_classifier (
	input wire logic [7:0] sense_code,
	input wire logic [7:0] cold_limit_code,
	input wire logic [7:0] cool_limit_code,
	input wire logic [7:0] warm_limit_code,
	input wire logic [7:0] hot_limit_code,
	output var thermal_profile_pkg::temp_zone_t zone
);
	// Hot checked first so overlapping limits fail safe
	always_comb begin
		if (sense_code <= hot_limit_code) begin
			zone = thermal_profile_pkg::zone_hot;
		end else if (sense_code >= cold_limit_code) begin
			zone = thermal_profile_pkg::zone_cold;
		end else if (sense_code <= warm_limit_code) begin
			zone = thermal_profile_pkg::zone_warm;
		end else if (sense_code >= cool_limit_code) begin
			zone = thermal_profile_pkg::zone_cool;
		end else begin
			zone = thermal_profile_pkg::zone_normal;
		end
	end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the thermal charge profile register bank.
// Assumes the design's same-clock strobe register port and registered zone outputs.
`timescale 1ns/1ns
`default_nettype none
`include "thermal_profile_defs.svh"
module tb_top;
	localparam logic [7:0] ID_VAL = 8'h5C; // Arbitrary identifier value
	logic sys_clk;
	logic arst_n;
	logic wr_en;
	logic rd_en;
	logic [7:0] reg_addr;
	logic [7:0] wr_data;
	logic [7:0] thermistor_sense;
	logic [7:0] rd_data;
	logic rd_valid;
	logic charge_suspend;
	logic [8:0] vbat_reduction_mv;
	logic [3:0] current_scale_eighths;
	thermal_profile_pkg::temp_zone_t zone_out;
	int failures;
	int cmp_count;
	logic [7:0] ofs [6] = '{`OFS_THERMAL_ADJUST, `OFS_COLD_LIMIT, `OFS_COOL_LIMIT,
		`OFS_WARM_LIMIT, `OFS_HOT_LIMIT, `OFS_PART_ID};
	logic [7:0] rst [6] = '{`RST_THERMAL_ADJUST, `RST_COLD_LIMIT, `RST_COOL_LIMIT,
		`RST_WARM_LIMIT, `RST_HOT_LIMIT, ID_VAL};

	thermal_charge_profile_regs #(.PART_ID_VALUE(ID_VAL)) DUT (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.reg_addr(reg_addr),
		.wr_data(wr_data),
		.thermistor_sense(thermistor_sense),
		.rd_data(rd_data),
		.rd_valid(rd_valid),
		.vbat_reduction_mv(vbat_reduction_mv),
		.current_scale_eighths(current_scale_eighths),
		.charge_suspend(charge_suspend),
		.zone_out(zone_out)
	);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		wr_en <= 1'b1;
		reg_addr <= a;
		wr_data <= d;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask

	// Write then read on the very next edge; the read must see the new byte
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		wr_en <= 1'b1;
		reg_addr <= a;
		wr_data <= d;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		chk({8'h00, rd_valid, rd_data}, {8'h00, 1'b1, d});
	endtask

	// Read answer is fixed at one cycle, so it is sampled just after the taking edge
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		chk({8'h00, rd_valid, rd_data}, {8'h00, 1'b1, e});
	endtask

	// Zone codes: normal 0, cool 1, warm 2, cold 3, hot 4; suspend only in cold or hot
	task automatic zchk(input logic [7:0] s, input logic [2:0] z, input logic [8:0] mv,
		input logic [3:0] sc);
		@(posedge sys_clk);
		thermistor_sense <= s;
		@(posedge sys_clk);
		#1;
		chk({zone_out, charge_suspend, vbat_reduction_mv, current_scale_eighths},
			{z, (z > 3'h2), mv, sc});
	endtask

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		arst_n = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		reg_addr = 8'h00;
		wr_data = 8'h00;
		thermistor_sense = 8'h50;
		failures = 0;
		cmp_count = 0;
		repeat (5) @(posedge sys_clk);
		arst_n <= 1'b1;
		// Synchronised reset lifts on the second edge; first request on the third
		repeat (2) @(posedge sys_clk);
		for (int i = 0; i < 6; i++) begin
			rd(ofs[i], rst[i]);
		end
		// Boundaries sit exactly on the reset limits; adjust code 3 warm, 4 current
		zchk(8'h50, 3'h0, 9'h000, 4'h8);
		zchk(8'h6D, 3'h1, 9'h000, 4'h4);
		zchk(8'h38, 3'h2, 9'h096, 4'h4);
		zchk(8'h27, 3'h4, 9'h000, 4'h8);
		zchk(8'h7C, 3'h3, 9'h000, 4'h8);
		wr(`OFS_THERMAL_ADJUST, 8'h77);
		zchk(8'h30, 3'h2, 9'h15E, 4'h1);
		wr(`OFS_THERMAL_ADJUST, 8'h00);
		zchk(8'h30, 3'h2, 9'h000, 4'h8);
		wr(`OFS_HOT_LIMIT, 8'h30);
		zchk(8'h30, 3'h4, 9'h000, 4'h8);
		wr_rd(`OFS_COLD_LIMIT, 8'h50);
		// Inverted reset values also set the reserved bits of the adjust register
		for (int i = 0; i < 5; i++) begin
			wr(ofs[i], ~rst[i]);
			rd(ofs[i], ~rst[i]);
		end
		wr(`OFS_PART_ID, ~ID_VAL);
		rd(`OFS_PART_ID, ID_VAL);
		wr(8'h66, 8'hFF);
		rd(8'h66, 8'h00);
		end_sim;
	end
endmodule
`default_nettype wire
